// *** psa_pkg.sv ***
// Package for program space address generator: widths, field positions, reset values.
// Assumes a single core clock domain; no software-reachable registers.
package psa_pkg;
  localparam int unsigned PSA_PROG_AW      = 24;
  localparam int unsigned PSA_DATA_W       = 16;
  localparam int unsigned PSA_PROG_DW      = 24;
  localparam int unsigned PSA_PAGE_W       = 8;
  localparam int unsigned PSA_PC_W         = 23;
  localparam int unsigned PSA_CFG_BIT      = 7;
  localparam int unsigned PSA_EA_MSB       = 15;
  localparam int unsigned PSA_PSV_LOW_W    = 15;
  localparam logic [7:0]  PSA_PAGE_RST     = 8'h00;
  localparam logic [23:0] PSA_ADDR_RST     = 24'h000000;
  localparam logic [15:0] PSA_DATA_RST     = 16'h0000;
  typedef enum logic [1:0] {
    PSA_SRC_FETCH = 2'b00,
    PSA_SRC_TABLE = 2'b01,
    PSA_SRC_PSV   = 2'b10
  } psa_src_t;
endpackage

// *** psa_addr_form.sv ***
// Combinational program address former for fetch, table and visibility paths.
// Assumes inputs are stable within a cycle; output is registered by the caller.
`timescale 1ns/1ps
`default_nettype none
module psa_addr_form
  import psa_pkg::*;
(
  input  wire logic [1:0]  src_in,
  input  wire logic [7:0]  table_page_in,
  input  wire logic [7:0]  vis_page_in,
  input  wire logic [15:0] ea_in,
  input  wire logic [22:0] pc_in,
  output logic      [23:0] addr_out
);
  always_comb begin
    unique case (psa_src_t'(src_in))
      PSA_SRC_TABLE: addr_out = {table_page_in, ea_in};
      // page plus low EA; EA15 dropped, bit 23 zero
      PSA_SRC_PSV:   addr_out = {1'b0, vis_page_in, ea_in[14:0]};
      PSA_SRC_FETCH: addr_out = {1'b0, pc_in[22:1], 1'b0};
      default:       addr_out = PSA_ADDR_RST;
    endcase
  end
endmodule // psa_addr_form
`default_nettype wire

// *** psa_gen.sv ***
// Top of program space address generator: page registers, access sequencing,
// read data return. Assumes core data path drives requests on sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Program words are 24 bits; data side uses 16-bit words.
// - Table accesses reach low word or upper byte, byte or word size.
// - Visibility window accesses are read-only; writes never reach memory.
// - Visibility reads return only the low 16 bits of the word.
// - Table address is table page over the 16-bit effective address.
// - Each table page value selects a 32K-word region.
// - Table page top bit selects configuration memory when set.
// - Visibility page register selects a 16K-word page.
// - Effective address bit 15 set forms address from visibility page.
// - Address bit 15 from visibility page bit 0; EA bit 15 ignored.
// - Visibility accesses reach user memory only, bit 23 zero.
module psa_gen
  import psa_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        table_page_we_in,
  input  wire logic        vis_page_we_in,
  input  wire logic [7:0]  page_wdata_in,
  input  wire logic        fetch_req_in,
  input  wire logic [22:0] pc_in,
  input  wire logic        table_read_instr_in,
  input  wire logic        table_write_instr_in,
  input  wire logic        table_high_in,
  input  wire logic        byte_mode_in,
  input  wire logic        data_rd_in,
  input  wire logic        data_wr_in,
  input  wire logic [15:0] data_effective_address_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic [23:0] pmem_rdata_in,
  output logic      [23:0] pmem_addr_out,
  output logic             pmem_rd_out,
  output logic             pmem_wr_out,
  output logic      [23:0] pmem_wdata_out,
  output logic      [2:0]  pmem_lane_out,
  output logic             cfg_space_out,
  output logic             psv_hit_out,
  output logic             psv_wr_blocked_out,
  output logic      [15:0] rdata_out,
  output logic             rdata_valid_out,
  output logic      [7:0]  table_page_select_out,
  output logic      [7:0]  visibility_page_select_out
);
  // Refused at elaboration, not at run time
  if (PSA_PROG_AW != PSA_PAGE_W + PSA_DATA_W) begin : g_width_chk
    $error("Program address width must be page plus data width");
  end

  logic [7:0]  table_page_reg, table_page_next;
  logic [7:0]  vis_page_reg, vis_page_next;
  logic [23:0] addr_reg, addr_next;
  logic        rd_reg, rd_next, wr_reg, wr_next;
  logic [23:0] wdat_reg, wdat_next;
  logic [2:0]  lane_reg, lane_next;
  logic        cfg_reg, cfg_next, psv_reg, psv_next, blk_reg, blk_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;
  // Pending read return info
  logic        pend_reg, pend_next, pend_high_reg, pend_high_next;
  logic        pend_byte_reg, pend_byte_next, pend_odd_reg, pend_odd_next;

  logic [1:0]  src;
  logic [23:0] formed;
  logic        tbl_req, psv_rd, psv_wr;

  assign tbl_req = table_read_instr_in | table_write_instr_in;
  // window hit on EA bit 15
  assign psv_rd  = !tbl_req && data_rd_in && data_effective_address_in[PSA_EA_MSB];
  assign psv_wr  = !tbl_req && data_wr_in && data_effective_address_in[PSA_EA_MSB];

  always_comb begin
    if (tbl_req)
      src = PSA_SRC_TABLE;
    else if (psv_rd)
      src = PSA_SRC_PSV;
    else
      src = PSA_SRC_FETCH;
  end

  psa_addr_form u_form (
    .src_in        (src),
    .table_page_in (table_page_reg),
    .vis_page_in   (vis_page_reg),
    .ea_in         (data_effective_address_in),
    .pc_in         (pc_in),
    .addr_out      (formed)
  );

  // Page registers
  always_comb begin
    table_page_next = table_page_we_in ? page_wdata_in : table_page_reg;
    vis_page_next   = vis_page_we_in ? page_wdata_in : vis_page_reg;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      table_page_reg <= PSA_PAGE_RST;
      vis_page_reg   <= PSA_PAGE_RST;
    end else begin
      table_page_reg <= table_page_next;
      vis_page_reg   <= vis_page_next;
    end
  end

  // Access issue
  always_comb begin
    addr_next = addr_reg;
    rd_next   = 1'b0;
    wr_next   = 1'b0;
    wdat_next = wdat_reg;
    lane_next = 3'b000;
    cfg_next  = 1'b0;
    psv_next  = 1'b0;
    blk_next  = psv_wr;
    pend_next = 1'b0;
    pend_high_next = pend_high_reg;
    pend_byte_next = pend_byte_reg;
    pend_odd_next  = pend_odd_reg;
    if (tbl_req) begin
      addr_next = formed;
      cfg_next  = table_page_reg[PSA_CFG_BIT];
      rd_next   = table_read_instr_in;
      wr_next   = table_write_instr_in && !table_read_instr_in;
      if (table_high_in)
        lane_next = 3'b100;
      else if (byte_mode_in)
        lane_next = data_effective_address_in[0] ? 3'b010 : 3'b001;
      else
        lane_next = 3'b011;
      if (table_high_in)
        wdat_next = {wdata_in[7:0], 16'h0000};
      else if (byte_mode_in)
        wdat_next = {8'h00, wdata_in[7:0], wdata_in[7:0]};
      else
        wdat_next = {8'h00, wdata_in};
      pend_next      = table_read_instr_in;
      pend_high_next = table_high_in;
      pend_byte_next = byte_mode_in;
      pend_odd_next  = data_effective_address_in[0];
    end else if (psv_rd) begin
      addr_next = formed;
      rd_next   = 1'b1;
      psv_next  = 1'b1;
      lane_next = 3'b011;
      pend_next = 1'b1;
      pend_high_next = 1'b0;
      pend_byte_next = byte_mode_in;
      pend_odd_next  = data_effective_address_in[0];
    end else if (fetch_req_in) begin
      addr_next = formed;
      rd_next   = 1'b1;
      lane_next = 3'b111;
    end
  end

  // Read return, memory data sampled in the strobe cycle, valid the cycle after
  // 24-bit word to 16-bit data
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = pend_reg;
    if (pend_reg) begin
      if (pend_high_reg)
        rdata_next = {8'h00, pmem_rdata_in[23:16]};
      else if (pend_byte_reg)
        rdata_next = {8'h00, pend_odd_reg ? pmem_rdata_in[15:8] : pmem_rdata_in[7:0]};
      else
        rdata_next = pmem_rdata_in[15:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_reg      <= PSA_ADDR_RST;
      rd_reg        <= 1'b0;
      wr_reg        <= 1'b0;
      wdat_reg      <= PSA_ADDR_RST;
      lane_reg      <= 3'b000;
      cfg_reg       <= 1'b0;
      psv_reg       <= 1'b0;
      blk_reg       <= 1'b0;
      pend_reg      <= 1'b0;
      pend_high_reg <= 1'b0;
      pend_byte_reg <= 1'b0;
      pend_odd_reg  <= 1'b0;
      rdata_reg     <= PSA_DATA_RST;
      rvalid_reg    <= 1'b0;
    end else begin
      addr_reg      <= addr_next;
      rd_reg        <= rd_next;
      wr_reg        <= wr_next;
      wdat_reg      <= wdat_next;
      lane_reg      <= lane_next;
      cfg_reg       <= cfg_next;
      psv_reg       <= psv_next;
      blk_reg       <= blk_next;
      pend_reg      <= pend_next;
      pend_high_reg <= pend_high_next;
      pend_byte_reg <= pend_byte_next;
      pend_odd_reg  <= pend_odd_next;
      rdata_reg     <= rdata_next;
      rvalid_reg    <= rvalid_next;
    end
  end

  assign pmem_addr_out              = addr_reg;
  assign pmem_rd_out                = rd_reg;
  assign pmem_wr_out                = wr_reg;
  assign pmem_wdata_out             = wdat_reg;
  assign pmem_lane_out              = lane_reg;
  assign cfg_space_out              = cfg_reg;
  assign psv_hit_out                = psv_reg;
  assign psv_wr_blocked_out         = blk_reg;
  assign rdata_out                  = rdata_reg;
  assign rdata_valid_out            = rvalid_reg;
  assign table_page_select_out      = table_page_reg;
  assign visibility_page_select_out = vis_page_reg;

  property p_tbl_addr;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      tbl_req |=> pmem_addr_out == {$past(table_page_reg), $past(data_effective_address_in)};
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("Table address wrong");

  property p_cfg_sel;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      tbl_req |=> cfg_space_out == $past(table_page_reg[PSA_CFG_BIT])
        && pmem_addr_out[23] == cfg_space_out;
  endproperty
  a_cfg_sel: assert property (p_cfg_sel) else $error("Config select mismatch");

  property p_psv_addr;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      psv_rd |=> pmem_addr_out[22:15] == $past(vis_page_reg)
                 && pmem_addr_out[14:0] == $past(data_effective_address_in[14:0]);
  endproperty
  a_psv_addr: assert property (p_psv_addr) else $error("Window address wrong");

  property p_psv_user;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      psv_hit_out |-> !pmem_addr_out[23] && !cfg_space_out;
  endproperty
  a_psv_user: assert property (p_psv_user) else $error("Window reached config");

  property p_psv_ro;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      psv_wr |=> !pmem_wr_out && psv_wr_blocked_out;
  endproperty
  a_psv_ro: assert property (p_psv_ro) else $error("Window write reached memory");

  property p_psv_low;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (psv_rd && !byte_mode_in) ##1 1'b1 |=> rdata_valid_out
        && rdata_out == $past(pmem_rdata_in[15:0]);
  endproperty
  a_psv_low: assert property (p_psv_low) else $error("Window read not low word");

  property p_fetch;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (fetch_req_in && !tbl_req && !psv_rd) |=> pmem_rd_out
        && pmem_addr_out == {1'b0, $past(pc_in[22:1]), 1'b0};
  endproperty
  a_fetch: assert property (p_fetch) else $error("Fetch address wrong");

  property p_high_lane;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (tbl_req && table_high_in) |=> pmem_lane_out == 3'b100;
  endproperty
  a_high_lane: assert property (p_high_lane) else $error("Upper byte lane wrong");

  property p_byte_lane;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (tbl_req && !table_high_in && byte_mode_in) |=>
        pmem_lane_out == ($past(data_effective_address_in[0]) ? 3'b010 : 3'b001);
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("Byte lane wrong");

  property p_high_ret;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      (table_read_instr_in && table_high_in) ##1 1'b1 |=> rdata_valid_out
        && rdata_out == {8'h00, $past(pmem_rdata_in[23:16])};
  endproperty
  a_high_ret: assert property (p_high_ret) else $error("Upper byte read wrong");

  property p_vis_load;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      vis_page_we_in |=> visibility_page_select_out == $past(page_wdata_in);
  endproperty
  a_vis_load: assert property (p_vis_load) else $error("Window page not loaded");

  property p_wr_src;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      pmem_wr_out |-> $past(table_write_instr_in) && !$past(table_read_instr_in);
  endproperty
  a_wr_src: assert property (p_wr_src) else $error("Write strobe without table write");
endmodule // psa_gen
`default_nettype wire

// *** psa_pmem_model.sv ***
// Program memory model facing the address generator: 24-bit words, one read port.
// Assumes the generator samples read data at the edge that ends its read strobe.
`timescale 1ns/1ps
`default_nettype none
module psa_pmem_model
  import psa_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [23:0] pmem_addr_in,
  input  wire logic        pmem_rd_in,
  output logic      [23:0] pmem_rdata_out
);
  logic [23:0] last_reg;
  logic [23:0] last_next;
  logic [23:0] word;

  always_comb begin
    word      = {pmem_addr_in[7:0] ^ 8'ha5, pmem_addr_in[15:0] ^ 16'h5c3a};
    last_next = pmem_rd_in ? word : last_reg;
  end

  // Outside a read the bus shows the inverse of the last word, never a stale copy
  assign pmem_rdata_out = pmem_rd_in ? word : ~last_reg;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      last_reg <= 24'h000000;
    end else begin
      last_reg <= last_next;
    end
  end
endmodule // psa_pmem_model
`default_nettype wire

// *** psa_gen_test.sv ***
// Self-checking bench for the program space address generator.
// Assumes the memory model answers reads within the strobe cycle.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module psa_gen_test;
  import psa_pkg::*;
  logic        sys_clk_in = 1'b0, rst_b_in = 1'b0;
  logic        table_page_we_in = 1'b0, vis_page_we_in = 1'b0, fetch_req_in = 1'b0;
  logic        table_read_instr_in = 1'b0, table_write_instr_in = 1'b0;
  logic        table_high_in = 1'b0, byte_mode_in = 1'b0, data_rd_in = 1'b0, data_wr_in = 1'b0;
  logic [7:0]  page_wdata_in = 8'h00;
  logic [22:0] pc_in = 23'h000000;
  logic [15:0] data_effective_address_in = 16'h0000, wdata_in = 16'h0000;
  logic [23:0] pmem_rdata_in, pmem_addr_out, pmem_wdata_out;
  logic        pmem_rd_out, pmem_wr_out, cfg_space_out, psv_hit_out, psv_wr_blocked_out;
  logic        rdata_valid_out;
  logic [2:0]  pmem_lane_out;
  logic [15:0] rdata_out;
  logic [7:0]  table_page_select_out, visibility_page_select_out;
  int          num_errors = 0, compares = 0;

  psa_gen i_dut (.sys_clk_in, .rst_b_in, .table_page_we_in, .vis_page_we_in, .page_wdata_in,
    .fetch_req_in, .pc_in, .table_read_instr_in, .table_write_instr_in, .table_high_in,
    .byte_mode_in, .data_rd_in, .data_wr_in, .data_effective_address_in, .wdata_in,
    .pmem_rdata_in, .pmem_addr_out, .pmem_rd_out, .pmem_wr_out, .pmem_wdata_out,
    .pmem_lane_out, .cfg_space_out, .psv_hit_out, .psv_wr_blocked_out, .rdata_out,
    .rdata_valid_out, .table_page_select_out, .visibility_page_select_out);
  psa_pmem_model i_pmem (.sys_clk_in, .rst_b_in, .pmem_addr_in(pmem_addr_out),
    .pmem_rd_in(pmem_rd_out), .pmem_rdata_out(pmem_rdata_in));

  always #4 sys_clk_in = ~sys_clk_in;

  function automatic logic [23:0] mem_word(input logic [23:0] a);
    return {a[7:0] ^ 8'ha5, a[15:0] ^ 16'h5c3a};
  endfunction

  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic set_page(input logic tbl, input logic [7:0] v);
    @(posedge sys_clk_in);
    table_page_we_in <= tbl;
    vis_page_we_in   <= !tbl;
    page_wdata_in    <= v;
    @(posedge sys_clk_in);
    table_page_we_in <= 1'b0;
    vis_page_we_in   <= 1'b0;
    #1;
    `CHK("page", v, tbl ? table_page_select_out : visibility_page_select_out)
  endtask

  // One request cycle; returns one step after the strobe cycle opens
  task automatic issue(input logic [3:0] k, input logic f, input logic hi, input logic bm,
                       input logic [15:0] ea);
    @(posedge sys_clk_in);
    {table_read_instr_in, table_write_instr_in, data_rd_in, data_wr_in} <= k;
    fetch_req_in              <= f;
    table_high_in             <= hi;
    byte_mode_in              <= bm;
    data_effective_address_in <= ea;
    wdata_in                  <= ~ea;
    @(posedge sys_clk_in);
    {table_read_instr_in, table_write_instr_in, data_rd_in, data_wr_in} <= 4'h0;
    fetch_req_in <= 1'b0;
    #1;
  endtask

  task automatic read_back(input logic [23:0] a, input logic [15:0] d);
    `CHK("rd strobe", 1'b1, pmem_rd_out)
    `CHK("rd addr", a, pmem_addr_out)
    @(posedge sys_clk_in);
    #1;
    `CHK("rdata valid", 1'b1, rdata_valid_out)
    `CHK("rdata", d, rdata_out)
  endtask

  task automatic t_reset();
    `CHK("addr rst", PSA_ADDR_RST, pmem_addr_out)
    `CHK("tpage rst", PSA_PAGE_RST, table_page_select_out)
    `CHK("vpage rst", PSA_PAGE_RST, visibility_page_select_out)
    `CHK("valid rst", 1'b0, rdata_valid_out)
    $display("test reset done");
  endtask

  task automatic t_table_rd();
    logic [7:0]  pg [4] = '{8'h12, 8'h7f, 8'h80, 8'hff};
    logic [15:0] ea [4] = '{16'h3456, 16'hffff, 16'h0000, 16'h8001};
    logic [23:0] w;
    foreach (pg[i]) begin
      set_page(1'b1, pg[i]);
      w = mem_word({pg[i], ea[i]});
      issue(4'h8, 1'b0, 1'b0, 1'b0, ea[i]);
      `CHK("cfg space", pg[i][7], cfg_space_out)
      read_back({pg[i], ea[i]}, w[15:0]);
      issue(4'h8, 1'b0, 1'b1, 1'b0, ea[i]);
      read_back({pg[i], ea[i]}, {8'h00, w[23:16]});
    end
    issue(4'h8, 1'b0, 1'b0, 1'b1, 16'h3457);
    `CHK("rd byte lane", 3'b010, pmem_lane_out)
    w = mem_word({8'hff, 16'h3457});
    read_back({8'hff, 16'h3457}, {8'h00, w[15:8]});
    $display("test table read done");
  endtask

  task automatic t_table_wr();
    logic [15:0] ea [4] = '{16'h2461, 16'h2462, 16'h2463, 16'h2465};
    logic [2:0]  ln [4] = '{3'b011, 3'b001, 3'b100, 3'b010};
    logic [1:0]  md [4] = '{2'b00, 2'b01, 2'b10, 2'b01};
    logic [23:0] wd [4] = '{24'h00db9e, 24'h009d9d, 24'h9c0000, 24'h009a9a};
    set_page(1'b1, 8'h81);
    foreach (ln[i]) begin
      issue(4'h4, 1'b0, md[i][1], md[i][0], ea[i]);
      `CHK("wr strobe", 1'b1, pmem_wr_out)
      `CHK("wr lanes", ln[i], pmem_lane_out)
      `CHK("wr addr", {8'h81, ea[i]}, pmem_addr_out)
      `CHK("wr data", wd[i], pmem_wdata_out)
    end
    $display("test table write done");
  endtask

  task automatic t_window();
    logic [7:0]  pg [2] = '{8'h35, 8'hff};
    logic [15:0] ea [2] = '{16'hc123, 16'h8000};
    logic [23:0] a;
    foreach (pg[i]) begin
      set_page(1'b0, pg[i]);
      a = {1'b0, pg[i], ea[i][14:0]};
      issue(4'h2, 1'b0, 1'b0, 1'b0, ea[i]);
      `CHK("window hit", 1'b1, psv_hit_out)
      `CHK("addr bit23", 1'b0, pmem_addr_out[23])
      `CHK("addr bit15", pg[i][0], pmem_addr_out[15])
      `CHK("window lanes", 3'b011, pmem_lane_out)
      read_back(a, 16'(mem_word(a)));
    end
    issue(4'h2, 1'b0, 1'b0, 1'b0, 16'h4123);
    `CHK("window miss", 1'b0, psv_hit_out)
    `CHK("window miss rd", 1'b0, pmem_rd_out)
    issue(4'h1, 1'b0, 1'b0, 1'b0, 16'h9234);
    `CHK("window wr strobe", 1'b0, pmem_wr_out)
    `CHK("window wr flag", 1'b1, psv_wr_blocked_out)
    $display("test window done");
  endtask

  task automatic t_fetch();
    @(posedge sys_clk_in);
    pc_in <= 23'h6abcdf;
    issue(4'h0, 1'b1, 1'b0, 1'b0, 16'h0000);
    `CHK("fetch addr", {1'b0, 23'h6abcdf & 23'h7ffffe}, pmem_addr_out)
    `CHK("fetch strobe", 1'b1, pmem_rd_out)
    `CHK("fetch lanes", 3'b111, pmem_lane_out)
    set_page(1'b1, 8'h44);
    issue(4'h8, 1'b1, 1'b0, 1'b0, 16'h1357);
    read_back({8'h44, 16'h1357}, 16'(mem_word({8'h44, 16'h1357})));
    $display("test fetch done");
  endtask

  // Reset in mid-run: pages clear, first request right after release
  task automatic t_mid_reset();
    set_page(1'b1, 8'h5a);
    set_page(1'b0, 8'ha5);
    @(posedge sys_clk_in);
    rst_b_in <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    t_reset();
    @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    issue(4'h8, 1'b0, 1'b0, 1'b0, 16'h0246);
    read_back({8'h00, 16'h0246}, 16'(mem_word({8'h00, 16'h0246})));
    $display("test mid reset done");
  endtask

  initial begin
    @(posedge sys_clk_in);
    #1;
    t_reset();
    @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    t_table_rd();
    t_table_wr();
    t_window();
    t_fetch();
    t_mid_reset();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    num_errors++;
    stop_test();
  end
endmodule // psa_gen_test
`default_nettype wire
